/* File: src/ismap_pkg.sv */
// Function
// - Requests are numbered 0 to 38 in a fixed order, and among equal requests the lower number wins.
// - The core timer is request 0 on vector 0, using flag bit 0, enable bit 0 and slot 0 of priority word 0, and it is not persistent.
// - The two software requests are requests 1 and 2 on vectors 1 and 2, using slots 1 and 2 of priority word 0, and they are not persistent.
// - The five external pin requests are 3, 8, 13, 18 and 23 on vectors 3, 7, 11, 15 and 19, and they are not persistent.
// - Timers one to five are requests 4, 9, 14, 19 and 24, compares one to five are 7, 12, 17, 22 and 27, and none is persistent.
// - Each capture channel has an error request and a data request on consecutive numbers, sharing one vector and one slot, and both are persistent.
// - Converter done is request 28 on vector 23, using slot 3 of priority word 5, and it is persistent.
// - Clock failure, calendar and flash event are requests 29, 30 and 31 on vectors 24, 25 and 26, and they are not persistent.
// - Requests 0 to 31 use the same bit of flag and enable word 0, and later requests use bit n-32 of word 1.
// - Each priority word holds four slots, each with a priority at bits 4:2, 12:10, 20:18 or 28:26 and a subpriority two bits below.
// - The comparators are requests 32, 33 and 34 on vectors 27, 28 and 29, and they are not persistent.
// - USB is request 35 on vector 30, using slot 2 of priority word 7, and it is persistent.
// - The serial fault, receive and transfer requests are 36, 37 and 38, share vector 31 and slot 3 of priority word 7, and are persistent.
// - A status register reports the six-bit vector and three-bit priority of the latest request presented to the core.
`default_nettype none
package ismap_pkg;
    // =========================================
    // sizes
    localparam int ISMAP_NREQ = 39;
    localparam int ISMAP_NVEC = 32;
    localparam int ISMAP_NPW = 8;
    // =========================================
    // register indices on the plain port
    localparam logic [3:0] ISMAP_A_FLAG0 = 4'h0;
    localparam logic [3:0] ISMAP_A_FLAG1 = 4'h1;
    localparam logic [3:0] ISMAP_A_EN0 = 4'h2;
    localparam logic [3:0] ISMAP_A_EN1 = 4'h3;
    localparam logic [3:0] ISMAP_A_STATE = 4'h4;
    localparam logic [3:0] ISMAP_A_PRIO0 = 4'h8;
    // =========================================
    // field positions of the state register and a slot
    localparam int ISMAP_VEC_LSB = 0;
    localparam int ISMAP_LVL_LSB = 8;
    localparam int ISMAP_SLOT_STRIDE = 8;
    localparam int ISMAP_PRI_LSB = 2;
    localparam int ISMAP_SUB_LSB = 0;
    localparam logic [31:0] ISMAP_RESET_WORD = 32'h0000_0000;
    // =========================================
    // request to vector map
    localparam logic [5:0] ISMAP_VEC_OF [ISMAP_NREQ] = '{
        6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h05, 6'h06, 6'h07, 6'h08,
        6'h09, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0D, 6'h0E, 6'h0F, 6'h10,
        6'h11, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h15, 6'h16, 6'h17, 6'h18,
        6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h1F, 6'h1F};
    // persistence per request, bit n for request n
    localparam logic [38:0] ISMAP_PERSIST = 39'h78_1631_8C60;
    // =========================================
    // carriers
    typedef struct packed {
        logic [5:0] vec;
        logic [2:0] lvl;
        logic [1:0] sub;
    } ismap_sel_t;
endpackage
`default_nettype wire

/* File: src/ismap_flag.sv */
`timescale 1ns/1ps
`default_nettype none
// one interrupt flag: sticky on the event, cleared by writing one
module ismap_flag #(
    parameter bit PERSIST = 1'b0
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic event_i,
    input wire logic clear_i,
    output logic flag_o
);
    logic flag_r;
    logic flag_nxt;
    logic line_r;
    logic line_nxt;
    logic set;
    // a persistent source sets on its level, so a clear while the line stays high is overridden
    // the others set only on a rising line, so one event is taken once however long it stands
    assign set = PERSIST ? event_i : (event_i && !line_r);
    // set wins over a clear in the same cycle, so no event is lost
    always_comb begin
        flag_nxt = flag_r;
        line_nxt = event_i;
        if (clear_i) begin
            flag_nxt = 1'b0;
        end
        if (set) begin
            flag_nxt = 1'b1;
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_r <= 1'b0;
            line_r <= 1'b0; // idle level of the line, so no false edge after reset
        end else begin
            flag_r <= flag_nxt;
            line_r <= line_nxt;
        end
    end
    assign flag_o = flag_r;
endmodule
`default_nettype wire

/* File: src/ismap_top.sv */
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ismap_top (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [38:0] src_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    output logic [5:0] vec_o,
    output logic [2:0] lvl_o
);
    import ismap_pkg::*;

    // =========================================
    // flags, one instance per request
    logic [38:0] flag;
    logic [38:0] clr;
    logic [63:0] en_r;
    logic [63:0] en_nxt;
    logic [31:0] prio_r [ISMAP_NPW];
    logic [31:0] prio_nxt [ISMAP_NPW];

    // write of one clears a flag; word 1 covers requests 32 and up
    always_comb begin
        clr = '0;
        if (wr_i && addr_i == ISMAP_A_FLAG0) begin
            clr[31:0] = wdata_i;
        end
        if (wr_i && addr_i == ISMAP_A_FLAG1) begin
            clr[38:32] = wdata_i[6:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < ISMAP_NREQ; g++) begin : g_flag
            ismap_flag #(
                .PERSIST(ISMAP_PERSIST[g])
            ) u_flag (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .event_i(src_i[g]),
                .clear_i(clr[g]),
                .flag_o(flag[g])
            );
        end
    endgenerate

    // =========================================
    // enable and priority words, plain read/write storage
    always_comb begin
        en_nxt = en_r;
        prio_nxt = prio_r;
        if (wr_i && addr_i == ISMAP_A_EN0) begin
            en_nxt[31:0] = wdata_i;
        end
        if (wr_i && addr_i == ISMAP_A_EN1) begin
            en_nxt[63:32] = {25'h0, wdata_i[6:0]};
        end
        if (wr_i && addr_i[3]) begin
            // only the slot fields are kept, the rest reads as zero
            prio_nxt[addr_i[2:0]] = wdata_i & 32'h1F1F_1F1F;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            en_r <= 64'h0;
            for (int i = 0; i < ISMAP_NPW; i++) begin
                prio_r[i] <= ISMAP_RESET_WORD;
            end
        end else begin
            en_r <= en_nxt;
            prio_r <= prio_nxt;
        end
    end

    // =========================================
    // arbitration: highest priority, then subpriority, then lowest request
    ismap_sel_t best;
    logic any;
    always_comb begin
        logic [4:0] slot;
        logic [2:0] p;
        logic [1:0] s;
        best = '0;
        any = 1'b0;
        slot = '0;
        p = '0;
        s = '0;
        for (int n = 0; n < ISMAP_NREQ; n++) begin
            // vector n sits in word n/4, slot n%4
            slot = ISMAP_VEC_OF[n][4:0];
            p = prio_r[slot[4:2]][slot[1:0]*ISMAP_SLOT_STRIDE + ISMAP_PRI_LSB +: 3];
            s = prio_r[slot[4:2]][slot[1:0]*ISMAP_SLOT_STRIDE + ISMAP_SUB_LSB +: 2];
            // flag, enable and nonzero priority are all needed
            if (flag[n] && en_r[n] && p != 3'h0) begin
                // strict compare keeps the lower number on a tie
                if (!any || p > best.lvl || (p == best.lvl && s > best.sub)) begin
                    best.vec = ISMAP_VEC_OF[n];
                    best.lvl = p;
                    best.sub = s;
                    any = 1'b1;
                end
            end
        end
    end

    // =========================================
    // presented request and the latest-state register
    logic irq_r;
    logic irq_nxt;
    logic [5:0] vec_r;
    logic [5:0] vec_nxt;
    logic [2:0] lvl_r;
    logic [2:0] lvl_nxt;
    always_comb begin
        irq_nxt = any;
        vec_nxt = vec_r;
        lvl_nxt = lvl_r;
        // values hold after the request goes away, as the latest presented
        if (any) begin
            vec_nxt = best.vec;
            lvl_nxt = best.lvl;
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_r <= 1'b0;
            vec_r <= 6'h00;
            lvl_r <= 3'h0;
        end else begin
            irq_r <= irq_nxt;
            vec_r <= vec_nxt;
            lvl_r <= lvl_nxt;
        end
    end
    assign irq_o = irq_r;
    assign vec_o = vec_r;
    assign lvl_o = lvl_r;

    // =========================================
    // read data, one cycle after the strobe; unmapped reads zero
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    always_comb begin
        rdata_nxt = 32'h0;
        if (rd_i) begin
            if (addr_i[3]) begin
                rdata_nxt = prio_r[addr_i[2:0]];
            end else begin
                case (addr_i)
                    ISMAP_A_FLAG0: rdata_nxt = flag[31:0];
                    ISMAP_A_FLAG1: rdata_nxt = {25'h0, flag[38:32]};
                    ISMAP_A_EN0: rdata_nxt = en_r[31:0];
                    ISMAP_A_EN1: rdata_nxt = en_r[63:32];
                    ISMAP_A_STATE: rdata_nxt = {21'h0, lvl_r, 2'h0, vec_r};
                    default: rdata_nxt = 32'h0;
                endcase
            end
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end
    assign rdata_o = rdata_r;
endmodule
`default_nettype wire

/* File: verification/ismap_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ========
// port checks of the source map
module ismap_top_monitor (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [38:0] src_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic irq_o,
    input wire logic [5:0] vec_o,
    input wire logic [2:0] lvl_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // read data only in the cycle after a read strobe
    chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0) else $error("rdata off cycle");
    chk_unmapped_zero: assert property (rd_i && addr_i inside {4'h5, 4'h6, 4'h7} |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    chk_state_gaps: assert property (rd_i && addr_i == 4'h4 |=> rdata_o[31:11] == 21'h0 && rdata_o[7:6] == 2'h0)
        else $error("state gaps");
    chk_prio_gaps: assert property (rd_i && addr_i[3] |=> (rdata_o & 32'hE0E0_E0E0) == 32'h0)
        else $error("priority gaps");
    chk_word1_width: assert property (rd_i && addr_i inside {4'h1, 4'h3} |=> rdata_o[31:7] == 25'h0)
        else $error("word one too wide");
    chk_lvl_nonzero: assert property (irq_o |-> lvl_o != 3'h0) else $error("irq at level 0");
    chk_vec_hold: assert property (!irq_o |-> $stable(vec_o) && $stable(lvl_o)) else $error("state moved idle");
    chk_reset_quiet: assert property ($rose(resetn_i) |-> !irq_o && rdata_o == 32'h0) else $error("out after reset");
    // main scenarios
    cover property (irq_o && vec_o == 6'h1F);
    cover property (rd_i && addr_i == 4'h4);
    cover property ($fell(irq_o));
endmodule
bind ismap_top ismap_top_monitor i_ismap_top_monitor (.clk_i(clk_i), .resetn_i(resetn_i), .src_i(src_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .vec_o(vec_o), .lvl_o(lvl_o));
`default_nettype wire

/* File: verification/ismap_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ========
// core side: keeps the last vector offered
module ismap_core_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic irq_i,
    input wire logic [5:0] vec_i,
    output logic [5:0] seen_vec_o
);
    // a vector only counts while the request line is high
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            seen_vec_o <= 6'h00;
        end else if (irq_i) begin
            seen_vec_o <= vec_i;
        end
    end
endmodule
`default_nettype wire

/* File: verification/ismap_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ismap_tb;
    import ismap_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [38:0] src_i = '0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o, m;
    logic irq_o, p;
    logic [5:0] vec_o, seen_vec;
    logic [2:0] lvl_o;
    logic [3:0] fa;
    int n_errors = 0;
    int checked = 0;
    int r, v, lv;
    int req_t [10] = '{0, 6, 28, 35, 38, 32, 1, 23, 27, 30};
    int vec_t [10] = '{0, 5, 23, 30, 31, 27, 1, 19, 22, 25};
    // ========
    // clock, design and core model
    always #5 clk_i = ~clk_i;
    ismap_top i_ismap_top (.clk_i(clk_i), .resetn_i(resetn_i), .src_i(src_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .vec_o(vec_o), .lvl_o(lvl_o));
    ismap_core_model i_ismap_core_model (.clk_i(clk_i), .resetn_i(resetn_i), .irq_i(irq_o), .vec_i(vec_o),
        .seen_vec_o(seen_vec));
    // ========
    // access tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // a gap cycle after each strobe keeps a strobe from being set twice in one step
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ========
    // main sequence: reset values, map table, arbitration
    initial begin
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (int a = 0; a < 5; a++) rd(4'(a), 32'h0);
        wr(4'h5, 32'hFFFF_FFFF);
        rd(4'h5, 32'h0);
        for (int i = 0; i < 10; i++) begin
            r = req_t[i];
            v = vec_t[i];
            m = 32'h1 << (r % 32);
            p = i > 0 && i < 5;
            lv = i % 7 + 1;
            fa = ISMAP_A_FLAG0 + 4'(r / 32);
            wr(ISMAP_A_PRIO0 + 4'(v / 4), 32'(lv) << (v % 4 * 8 + 2));
            wr(ISMAP_A_EN0 + 4'(r / 32), m);
            @(posedge clk_i);
            src_i[r] <= 1'b1;
            // every line stays high through the clear below, so only persistence may set it again
            @(posedge clk_i);
            repeat (2) @(posedge clk_i);
            #1 chk({25'h0, irq_o, vec_o}, {26'h1, 6'(v)});
            rd(fa, m);
            rd(ISMAP_A_STATE, (32'(lv) << 8) | 32'(v));
            chk(32'({lvl_o, seen_vec}), 32'({3'(lv), 6'(v)}));
            wr(fa, m);
            rd(fa, p ? m : 32'h0);
            @(posedge clk_i);
            src_i[r] <= 1'b0;
            // disable first: a persistent flag is still set, so only the enable holds the line low
            wr(ISMAP_A_EN0 + 4'(r / 32), 32'h0);
            @(posedge clk_i);
            #1 chk(32'(irq_o), 32'h0);
            wr(fa, m);
        end
        // equal levels on vectors 6 and 7, request 4 left at level zero
        wr(ISMAP_A_PRIO0 + 4'h1, 32'h0C0C_0000);
        wr(ISMAP_A_EN0, 32'h0000_0190);
        @(posedge clk_i);
        src_i <= 39'h190;
        @(posedge clk_i);
        src_i <= 39'h0;
        repeat (2) @(posedge clk_i);
        #1 chk(32'({irq_o, lvl_o, vec_o}), 32'({1'b1, 3'h3, 6'h06}));
        wr(ISMAP_A_FLAG0, 32'h0000_0180);
        rd(ISMAP_A_FLAG0, 32'h0000_0010);
        chk(32'(irq_o), 32'h0);
        // same levels again, but vector 7 now has the higher subpriority
        wr(ISMAP_A_PRIO0 + 4'h1, 32'h0D0C_0000);
        @(posedge clk_i);
        src_i <= 39'h180;
        @(posedge clk_i);
        src_i <= 39'h0;
        repeat (2) @(posedge clk_i);
        #1 chk(32'({irq_o, lvl_o, vec_o}), 32'({1'b1, 3'h3, 6'h07}));
        report_and_stop();
    end
    // watchdog: the sequence needs well under 600 cycles
    initial begin
        repeat (2000) @(posedge clk_i);
        n_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
